//--- include/lcrc_pkg.sv
// Shared constants and types for the logic cell register control block
package lcrc_pkg;

   // Asynchronous control modes, one-hot
   typedef enum logic [5:0]
   {
      LCRC_ASYNC_CLR     = 6'h01,  // Clear only
      LCRC_ASYNC_PRE     = 6'h02,  // Preset only
      LCRC_ASYNC_CLRPRE  = 6'h04,  // Preset on line a, clear on line b
      LCRC_ASYNC_LDCLR   = 6'h08,  // Load on line a, clear on line b
      LCRC_ASYNC_LDPRE   = 6'h10,  // Load on line a, preset on line b
      LCRC_ASYNC_LD      = 6'h20   // Load on line a only
   } lcrc_async_mode_t;

   // Counter modes
   localparam logic LCRC_CNT_UPDOWN    = 1'b0;  // Up/down with load
   localparam logic LCRC_CNT_CLEARABLE = 1'b1;  // Up only, sync clear

   // Direction encoding on the direction input of a cell
   localparam logic LCRC_DIR_UP   = 1'b1;
   localparam logic LCRC_DIR_DOWN = 1'b0;

   // Truth tables of the two 3-input lookups, index {dir, carry, q}
   localparam logic [7:0] LCRC_LUT_SUM   = 8'h66;  // q xor carry
   localparam logic [7:0] LCRC_LUT_CARRY = 8'h84;  // Up: q&c, down: ~q&c

   // Values after reset, and resolved bus levels
   localparam logic LCRC_RST_ZERO    = 1'b0;
   localparam logic LCRC_RST_ONE     = 1'b1;
   localparam logic LCRC_BUS_IDLE    = 1'b1;  // Floating bus reads high
   localparam logic LCRC_BUS_CONTEND = 1'b0;  // Contended bus reads low

   // Default sizes
   localparam int LCRC_CNT_WIDTH   = 8;
   localparam int LCRC_BUS_WIDTH   = 8;
   localparam int LCRC_BUS_DRIVERS = 4;

endpackage : lcrc_pkg

//--- src/lcrc_cell.sv
// One logic cell: two lookups, load mux, sync clear and the register
`timescale 1ns/1ps
`default_nettype none

module lcrc_cell
   import lcrc_pkg::*;
#(
   parameter logic RESET_VAL = LCRC_RST_ZERO  // Value under chip reset
)
(
   // Clock and chip-wide reset
   input  wire logic clk_in,
   input  wire logic nrst_in,
   // Synchronous controls
   input  wire logic clk_en_in,     // Clock enable
   input  wire logic dir_in,        // Count direction
   input  wire logic casc_in,       // Cascade input, sync clear
   input  wire logic clr_mode_in,   // Cascade input acts as clear
   input  wire logic carry_in,      // Carry from the previous cell
   input  wire logic load_in,       // Synchronous load select
   input  wire logic load_data_in,  // Synchronous load value
   // Register asynchronous controls, active low
   input  wire logic clr_n_in,
   input  wire logic pre_n_in,
   // Results
   output var  logic q_out,         // Register output
   output      logic carry_out      // Fast carry to the next cell
);

   ////////////////////////////////////////////////////////////////////////
   // Lookup evaluation

   // Reads one bit of a 3-input truth table
   function automatic logic lcrc_lut3(input logic [7:0] mask,
                                      input logic       a,
                                      input logic       b,
                                      input logic       c);
      lcrc_lut3 = mask[{c, b, a}];
   endfunction : lcrc_lut3

   logic sum;     // Counter data lookup
   logic next_q;  // Value taken on the clock edge

   // Two lookups, one for the data and one for the carry
   always_comb
   begin
      sum       = lcrc_lut3(LCRC_LUT_SUM, q_out, carry_in, dir_in);
      carry_out = lcrc_lut3(LCRC_LUT_CARRY, q_out, carry_in, dir_in);
      // Load mux ahead of the register
      next_q    = load_in ? load_data_in : sum;
      // Mux result gated by the inverted clear
      next_q    = next_q & ~(clr_mode_in & casc_in);
   end

   ////////////////////////////////////////////////////////////////////////
   // Register with chip reset, clear and preset

   // Chip reset first, then clear over preset, then the clocked path
   always_ff @(posedge clk_in or negedge nrst_in or negedge clr_n_in
               or negedge pre_n_in)
   begin
      if (!nrst_in)
         q_out <= RESET_VAL;
      else if (!clr_n_in)
         q_out <= 1'b0;
      else if (!pre_n_in)
         q_out <= 1'b1;
      else if (clk_en_in)
         q_out <= next_q;
   end

endmodule : lcrc_cell

`default_nettype wire

//--- src/lcrc_top.sv
// Logic cell register control: counter chain, async controls, shared bus
`timescale 1ns/1ps
`default_nettype none

module lcrc_top
   import lcrc_pkg::*;
#(
   parameter int   CNT_WIDTH   = LCRC_CNT_WIDTH,   // Cells in the chain
   parameter int   BUS_WIDTH   = LCRC_BUS_WIDTH,   // Shared bus width
   parameter int   BUS_DRIVERS = LCRC_BUS_DRIVERS, // Bus drivers
   parameter logic PRESET_ON_RESET = LCRC_RST_ZERO // Reset value of cells
)
(
   // Clock and chip-wide reset
   input  wire logic                           clk_in,
   input  wire logic                           nrst_in,
   // Configuration, held static
   input  wire logic                           counter_mode_in,
   input  wire lcrc_async_mode_t               async_mode_in,
   input  wire logic                           clr_src_sel_in,
   // Synchronous counter controls
   input  wire logic                           cnt_en_in,
   input  wire logic                           clk_en_in,
   input  wire logic                           up_dn_in,
   input  wire logic                           sync_load_in,
   input  wire logic [CNT_WIDTH-1:0]           sync_load_data_in,
   input  wire logic                           sync_clr_in,
   // Asynchronous controls, active low
   input  wire logic                           async_ctrl_a_n_in,
   input  wire logic                           async_ctrl_b_n_in,
   input  wire logic [CNT_WIDTH-1:0]           async_load_value_in,
   // Shared bus drivers
   input  wire logic [BUS_DRIVERS*BUS_WIDTH-1:0] bus_data_in,
   input  wire logic [BUS_DRIVERS-1:0]         bus_oe_in,
   // Results
   output var  logic [CNT_WIDTH-1:0]           count_out,
   output var  logic [BUS_WIDTH-1:0]           bus_out
);

   ////////////////////////////////////////////////////////////////////////
   // Asynchronous control decode

   // Maps the two lines and one load bit to {clr_n, pre_n} of a cell
   function automatic logic [1:0] lcrc_async_decode(
      input lcrc_async_mode_t mode,
      input logic             a_n,
      input logic             b_n,
      input logic             sel,
      input logic             value);
      logic clr_n;
      logic pre_n;
      // Unused controls idle high
      clr_n = 1'b1;
      pre_n = 1'b1;
      case (mode)
         LCRC_ASYNC_CLR:
         begin
            // Either line may drive the clear
            clr_n = sel ? b_n : a_n;
         end
         LCRC_ASYNC_PRE:
         begin
            // Selected line presets; load value unused
            pre_n = sel ? b_n : a_n;
         end
         LCRC_ASYNC_CLRPRE:
         begin
            // Line a loads a forced one, line b clears
            pre_n = a_n;
            clr_n = b_n;
         end
         LCRC_ASYNC_LDCLR:
         begin
            // Line a steers both; line b only the clear
            pre_n = a_n | ~value;
            clr_n = (a_n | value) & b_n;
         end
         LCRC_ASYNC_LDPRE:
         begin
            // Line b presets, line a loads
            pre_n = (a_n | ~value) & b_n;
            clr_n = a_n | value;
         end
         LCRC_ASYNC_LD:
         begin
            // Line a loads through preset or clear
            pre_n = a_n | ~value;
            clr_n = a_n | value;
         end
         default:
         begin
            clr_n = 1'b1;
            pre_n = 1'b1;
         end
      endcase
      lcrc_async_decode = {clr_n, pre_n};
   endfunction : lcrc_async_decode

   ////////////////////////////////////////////////////////////////////////
   // Counter chain

   logic [CNT_WIDTH:0]   carry;  // Carry chain, bit 0 is count enable
   logic [CNT_WIDTH-1:0] clr_n;  // Per-cell clear, active low
   logic [CNT_WIDTH-1:0] pre_n;  // Per-cell preset, active low
   logic                 dir;    // Direction seen by every cell
   logic                 casc;   // Cascade line seen by every cell

   // Count enable enters the chain as the carry into bit 0; kept out of
   // the process below so the chain vector has no mixed drivers
   assign carry[0] = cnt_en_in;

   // Clearable mode pins direction up and reuses the cascade line
   always_comb
   begin
      if (counter_mode_in == LCRC_CNT_CLEARABLE)
      begin
         dir  = LCRC_DIR_UP;
         casc = sync_clr_in;
      end
      else
      begin
         dir  = up_dn_in;
         casc = 1'b0;
      end
   end

   // One cell per bit; carry ripples as the fast chain
   generate
      for (genvar i = 0; i < CNT_WIDTH; i++)
      begin : g_cell
         // Decode per bit since the load value differs by bit
         assign {clr_n[i], pre_n[i]} =
            lcrc_async_decode(async_mode_in, async_ctrl_a_n_in,
                              async_ctrl_b_n_in, clr_src_sel_in,
                              async_load_value_in[i]);

         lcrc_cell #(
            .RESET_VAL    (PRESET_ON_RESET)
         ) u_cell (
            .clk_in       (clk_in),
            .nrst_in      (nrst_in),
            .clk_en_in    (clk_en_in),
            .dir_in       (dir),
            .casc_in      (casc),
            .clr_mode_in  (counter_mode_in),
            .carry_in     (carry[i]),
            .load_in      (sync_load_in),
            .load_data_in (sync_load_data_in[i]),
            .clr_n_in     (clr_n[i]),
            .pre_n_in     (pre_n[i]),
            .q_out        (count_out[i]),
            .carry_out    (carry[i+1])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Shared bus emulation

   logic [BUS_WIDTH-1:0] next_bus;   // Resolved bus value
   logic                 any_oe;     // At least one driver on
   logic                 multi_oe;   // Two or more drivers on

   // Mux replaces a real tri-state net; no float, no fight
   always_comb
   begin
      next_bus = '0;
      any_oe   = 1'b0;
      multi_oe = 1'b0;
      for (int d = 0; d < BUS_DRIVERS; d++)
      begin
         if (bus_oe_in[d])
         begin
            multi_oe = multi_oe | any_oe;
            any_oe   = 1'b1;
            next_bus = bus_data_in[d*BUS_WIDTH +: BUS_WIDTH];
         end
      end
      if (!any_oe)
         next_bus = {BUS_WIDTH{LCRC_BUS_IDLE}};
      else if (multi_oe)
         next_bus = {BUS_WIDTH{LCRC_BUS_CONTEND}};
   end

   // Registered so the output comes from a flop; costs one cycle
   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         bus_out <= {BUS_WIDTH{LCRC_BUS_IDLE}};
      else
         bus_out <= next_bus;
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks

   logic async_idle;  // No cell has a clear or preset asserted

   assign async_idle = (&clr_n) & (&pre_n);

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!nrst_in);

   // Two edges with a condition held
   sequence s_held(logic c);
      c ##1 c;
   endsequence

   // Clocked update with no async control in the way
   sequence s_clocked(logic c);
      (async_idle && clk_en_in && c) ##1 async_idle;
   endsequence

   a_clr_select: assert property (
      s_held(async_mode_in == LCRC_ASYNC_CLR &&
             !(clr_src_sel_in ? async_ctrl_b_n_in : async_ctrl_a_n_in))
      |-> count_out == '0)
      else $error("Selected clear line did not clear the counter");

   a_async_load: assert property (
      s_held(async_mode_in == LCRC_ASYNC_LD && !async_ctrl_a_n_in &&
             $stable(async_load_value_in))
      |-> count_out == async_load_value_in)
      else $error("Asynchronous load value not held in counter");

   a_clrpre_set: assert property (
      s_held(async_mode_in == LCRC_ASYNC_CLRPRE && !async_ctrl_a_n_in &&
             async_ctrl_b_n_in)
      |-> count_out == '1)
      else $error("Preset line did not set the counter");

   a_clr_wins: assert property (
      s_held(async_mode_in == LCRC_ASYNC_LDCLR && !async_ctrl_a_n_in &&
             !async_ctrl_b_n_in)
      |-> count_out == '0)
      else $error("Clear lost against an asynchronous load");

   a_ldpre_set: assert property (
      s_held(async_mode_in == LCRC_ASYNC_LDPRE && async_ctrl_a_n_in &&
             !async_ctrl_b_n_in)
      |-> count_out == '1)
      else $error("Preset line did not set the counter");

   a_sync_load: assert property (
      s_clocked(sync_load_in &&
                !(counter_mode_in == LCRC_CNT_CLEARABLE && sync_clr_in))
      |-> count_out == $past(sync_load_data_in))
      else $error("Synchronous load value not taken");

   a_sync_clear: assert property (
      s_clocked(counter_mode_in == LCRC_CNT_CLEARABLE && sync_clr_in)
      |-> count_out == '0)
      else $error("Synchronous clear did not zero the counter");

   a_count_up: assert property (
      s_clocked(counter_mode_in == LCRC_CNT_UPDOWN && cnt_en_in &&
                up_dn_in && !sync_load_in)
      |-> count_out == CNT_WIDTH'($past(count_out) + 1'b1))
      else $error("Up count did not advance by one");

   a_count_down: assert property (
      s_clocked(counter_mode_in == LCRC_CNT_UPDOWN && cnt_en_in &&
                !up_dn_in && !sync_load_in)
      |-> count_out == CNT_WIDTH'($past(count_out) - 1'b1))
      else $error("Down count did not step back by one");

   a_one_dir: assert property (
      s_clocked(counter_mode_in == LCRC_CNT_CLEARABLE && cnt_en_in &&
                !up_dn_in && !sync_load_in && !sync_clr_in)
      |-> count_out == CNT_WIDTH'($past(count_out) + 1'b1))
      else $error("Clearable counter did not count up");

   a_bus_float: assert property (
      (bus_oe_in == '0) |=> bus_out == '1)
      else $error("Undriven bus did not read high");

   a_bus_contend: assert property (
      ($countones(bus_oe_in) > 1) |=> bus_out == '0)
      else $error("Contended bus did not read low");

endmodule : lcrc_top

`default_nettype wire

//--- bench/lcrc_bus_drivers.sv
// Far-side logic model driving the emulated shared bus of a cell group
`timescale 1ns/1ps
`default_nettype none

module lcrc_bus_drivers
   import lcrc_pkg::*;
(
   // Clock
   input  wire logic                                   clk_in,
   // Driver values toward the block
   output var  logic [LCRC_BUS_DRIVERS*LCRC_BUS_WIDTH-1:0] bus_data_out,
   output var  logic [LCRC_BUS_DRIVERS-1:0]            bus_oe_out
);

   ////////////////////////////////////////////////////////////////////////
   // New drivers just after each edge; random enables give idle, single
   // and contended cycles, which real logic around the bus can produce
   initial
   begin
      bus_data_out = '0;
      bus_oe_out   = '0;
      forever
      begin
         @(posedge clk_in);
         #1;
         bus_data_out = {$urandom};
         bus_oe_out   = LCRC_BUS_DRIVERS'($urandom);
      end
   end

endmodule : lcrc_bus_drivers

`default_nettype wire

//--- bench/test_logic_cell_register_control.sv
// Self-checking bench for the logic cell register control block
`timescale 1ns/1ps
`default_nettype none

module test_logic_cell_register_control
   import lcrc_pkg::*;
;
   localparam int CW = LCRC_CNT_WIDTH;   // Counter width
   localparam int BW = LCRC_BUS_WIDTH;   // Bus width
   localparam int ND = LCRC_BUS_DRIVERS; // Bus drivers

   logic                 clk_in;       // Clock
   logic                 nrst_in;      // Chip-wide reset
   logic                 counter_mode_in, clr_src_sel_in;
   lcrc_async_mode_t     async_mode_in;
   logic                 cnt_en_in, clk_en_in, up_dn_in;
   logic                 sync_load_in, sync_clr_in;
   logic [CW-1:0]        sync_load_data_in, async_load_value_in;
   logic                 async_ctrl_a_n_in, async_ctrl_b_n_in;
   wire logic [ND*BW-1:0] bus_data_in;  // From far-side model
   wire logic [ND-1:0]   bus_oe_in;
   logic [CW-1:0]        count_out;
   logic [BW-1:0]        bus_out;
   logic [CW-1:0]        exp;          // Reference counter register
   int                   n_mismatch, n_compared;

   ////////////////////////////////////////////////////////////////////////
   // Design and far side
   lcrc_top dut_u (.clk_in(clk_in), .nrst_in(nrst_in),
      .counter_mode_in(counter_mode_in), .async_mode_in(async_mode_in),
      .clr_src_sel_in(clr_src_sel_in), .cnt_en_in(cnt_en_in),
      .clk_en_in(clk_en_in), .up_dn_in(up_dn_in),
      .sync_load_in(sync_load_in), .sync_load_data_in(sync_load_data_in),
      .sync_clr_in(sync_clr_in), .async_ctrl_a_n_in(async_ctrl_a_n_in),
      .async_ctrl_b_n_in(async_ctrl_b_n_in),
      .async_load_value_in(async_load_value_in),
      .bus_data_in(bus_data_in), .bus_oe_in(bus_oe_in),
      .count_out(count_out), .bus_out(bus_out));

   lcrc_bus_drivers far_u (.clk_in(clk_in), .bus_data_out(bus_data_in),
      .bus_oe_out(bus_oe_in));

   // 50 MHz clock
   initial
   begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end

   ////////////////////////////////////////////////////////////////////////
   // Compare and count
   task automatic chk(input logic [7:0] seen, input logic [7:0] want);
      n_compared++;
      if (seen !== want)
      begin
         n_mismatch++;
         $display("FAIL t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask : chk

   // Verdict and end of run
   task automatic finish_test();
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : finish_test

   // Resolved bus: idle reads high, contention reads low
   function automatic logic [BW-1:0] bus_ref();
      int n;
      logic [BW-1:0] v;
      n = 0;
      v = 8'hFF;
      for (int d = 0; d < ND; d++)
         if (bus_oe_in[d])
         begin
            n++;
            v = bus_data_in[d*BW +: BW];
         end
      return (n > 1) ? 8'h00 : v;
   endfunction : bus_ref

   ////////////////////////////////////////////////////////////////////////
   // One clock: update the reference from pre-edge inputs, then compare
   task automatic tick();
      logic [BW-1:0] bx;
      @(posedge clk_in);
      bx = nrst_in ? bus_ref() : 8'hFF;
      if (!nrst_in)
         exp = 8'h00;
      else if (clk_en_in && async_ctrl_a_n_in && async_ctrl_b_n_in)
      begin
         if (counter_mode_in && sync_clr_in)
            exp = 8'h00;
         else if (sync_load_in)
            exp = sync_load_data_in;
         else if (cnt_en_in)
            exp = (counter_mode_in || up_dn_in) ? exp + 8'h01 : exp - 8'h01;
      end
      #1;
      chk(count_out, exp);
      chk(bus_out, bx);
   endtask : tick

   // One asynchronous case; line choice ab: bit 0 line a, bit 1 line b
   task automatic async_case(input int m, input int s, input int ab);
      logic [CW-1:0] v;
      logic          a, b, ln;
      v = CW'($urandom);
      a = ab[0];
      b = ab[1];
      ln = s[0] ? b : a;
      async_mode_in = lcrc_async_mode_t'(6'h01 << m);
      clr_src_sel_in = s[0];
      async_load_value_in = v;
      #2;
      // Lines move only after mode and value settle, so no glitch
      async_ctrl_a_n_in = !a;
      async_ctrl_b_n_in = !b;
      #2;
      case (async_mode_in)
         LCRC_ASYNC_CLR:    if (ln) exp = 8'h00;
         LCRC_ASYNC_PRE:    if (ln) exp = 8'hFF;
         LCRC_ASYNC_CLRPRE: exp = b ? 8'h00 : a ? 8'hFF : exp;
         LCRC_ASYNC_LDCLR:  exp = b ? 8'h00 : a ? v : exp;
         LCRC_ASYNC_LDPRE:  exp = b ? 8'hFF : a ? v : exp;
         default:           if (a) exp = v;
      endcase
      chk(count_out, exp);
      // Lines held over three edges so the held-level checks see them
      repeat (3) tick();
      async_ctrl_a_n_in = 1'b1;
      async_ctrl_b_n_in = 1'b1;
      tick();
   endtask : async_case

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      void'($urandom(32'h4723962C));
      {n_mismatch, n_compared} = '0;
      exp = 8'h00;
      nrst_in = 1'b0;
      {counter_mode_in, clr_src_sel_in, cnt_en_in, up_dn_in} = '0;
      {sync_load_in, sync_clr_in, clk_en_in} = '0;
      async_mode_in = LCRC_ASYNC_LD;
      {sync_load_data_in, async_load_value_in} = '0;
      {async_ctrl_a_n_in, async_ctrl_b_n_in} = 2'h3;
      repeat (6) tick();
      nrst_in = 1'b1;
      // Random synchronous traffic in both counter modes
      for (int cm = 0; cm < 2; cm++)
      begin
         counter_mode_in = cm[0];
         repeat (300)
         begin
            tick();
            cnt_en_in = ($urandom % 4) != 0;
            clk_en_in = ($urandom % 4) != 0;
            up_dn_in = 1'($urandom);
            sync_load_in = ($urandom % 8) == 0;
            sync_clr_in = ($urandom % 8) == 0;
            sync_load_data_in = CW'($urandom);
            async_load_value_in = CW'($urandom);
         end
      end
      // Every asynchronous mode, both line choices, clocks disabled
      clk_en_in = 1'b0;
      for (int m = 0; m < 6; m++)
         for (int s = 0; s < 2; s++)
            for (int ab = 1; ab < 4; ab++)
               if (!(m == 4 && ab == 3))
                  async_case(m, s, ab);
      // Chip reset beats an active asynchronous load
      async_mode_in = LCRC_ASYNC_LD;
      async_load_value_in = 8'h5A;
      #2;
      async_ctrl_a_n_in = 1'b0;
      #2;
      nrst_in = 1'b0;
      #2;
      chk(count_out, 8'h00);
      chk(bus_out, 8'hFF);
      async_ctrl_a_n_in = 1'b1;
      exp = 8'h00;
      tick();
      nrst_in = 1'b1;
      clk_en_in = 1'b1;
      repeat (4) tick();
      finish_test();
   end

   // Watchdog: the run needs about 750 cycles, well under the 5000 allowed
   initial
   begin
      #100000;
      n_mismatch++;
      finish_test();
   end

endmodule : test_logic_cell_register_control

`default_nettype wire
